// ---- design/user_register_block_params.svh ----
`ifndef USER_REGISTER_BLOCK_PARAMS_SVH
`define USER_REGISTER_BLOCK_PARAMS_SVH

// ----------------------------------------
// Widths
// ----------------------------------------
`define UR_WORD_ADDR_W 13
`define UR_BYTE_ADDR_W 15
`define UR_BUF_ADDR_W 11
`define UR_SUBQ_DEPTH 16

// ----------------------------------------
// Window selection on byte address bits 14:13 and 9:8
// ----------------------------------------
`define UR_TOP_REGS 2'h0
`define UR_TOP_IDEN 2'h1
`define UR_TOP_CBUF 2'h2
`define UR_SUB_CTRL 2'h0
`define UR_SUB_STAT 2'h1
`define UR_SUB_CSUB 2'h2
`define UR_SUB_CCOMP 2'h3

// ----------------------------------------
// Write-only control words (byte offsets)
// ----------------------------------------
`define UR_OFS_START_LO 15'h0000
`define UR_OFS_START_HI 15'h0004
`define UR_OFS_LEN_LO 15'h0008
`define UR_OFS_LEN_HI 15'h000c
`define UR_OFS_COMMAND 15'h0010
`define UR_OFS_PATTERN 15'h0014
`define UR_OFS_TIMEOUT 15'h0020

// ----------------------------------------
// Read-only status words (byte offsets)
// ----------------------------------------
`define UR_OFS_CORE_STATUS 15'h0100
`define UR_OFS_CAP_LO 15'h0104
`define UR_OFS_CAP_HI 15'h0108
`define UR_OFS_ERROR_KIND 15'h010c
`define UR_OFS_LINK_STATUS 15'h0110
`define UR_OFS_COMPLETION 15'h0114
`define UR_OFS_CAPABILITY 15'h0118
`define UR_OFS_PROBE_PINS 15'h011c

// ----------------------------------------
// Field positions
// ----------------------------------------
`define UR_BIT_BUSY 0
`define UR_BIT_ERROR 1
`define UR_BIT_VERIFY_FAIL 2
`define UR_BIT_SECTOR_MODE 31
`define UR_BIT_LINK_UP 0
`define UR_BIT_SPEED_MSB 16

// ----------------------------------------
// Reset values
// ----------------------------------------
`define UR_RST_WORD 32'h0000_0000
`define UR_RST_WIDE 48'h0000_0000_0000
`define UR_RST_CODE 3'h0

`endif

// ---- design/user_register_block_pkg.sv ----
package user_register_block_pkg;

    // Decoded access window
    typedef enum logic [2:0] {
        WIN_CTRL  = 3'b000,
        WIN_STAT  = 3'b001,
        WIN_CSUB  = 3'b010,
        WIN_CCOMP = 3'b011,
        WIN_IDEN  = 3'b100,
        WIN_CBUF  = 3'b101,
        WIN_NONE  = 3'b110
    } window_e;

    // Command codes toward the core
    typedef enum logic [2:0] {
        CMD_IDENTIFY = 3'b000,
        CMD_SHUTDOWN = 3'b001,
        CMD_WRITE    = 3'b010,
        CMD_READ     = 3'b011,
        CMD_HEALTH   = 3'b100,
        CMD_RSVD5    = 3'b101,
        CMD_FLUSH    = 3'b110,
        CMD_RSVD7    = 3'b111
    } command_e;

    // Test data pattern codes
    typedef enum logic [2:0] {
        PAT_INCREMENT = 3'b000,
        PAT_DECREMENT = 3'b001,
        PAT_ZEROS     = 3'b010,
        PAT_ONES      = 3'b011,
        PAT_LFSR      = 3'b100
    } pattern_e;

endpackage

// ---- design/user_register_block.sv ----
`timescale 1ns/1ps
`include "user_register_block_params.svh"

// How it works
// - Control window 0x0000-0x00FF is write-only
// - Custom parameter window 0x0200-0x02FF write-only
// - Status window 0x0100-0x01FF is read-only
// - Custom status window 0x0300-0x03FF read-only
// - Identify buffer readable, never written
// - Custom buffer forwarded for writes and reads
// - Upper address bits pick the active unit
// - Whole-word writes, byte lanes ignored
// - Two-level read mux: low then high bits
// - Read valid is request through two flops
// - Start sector from two words, 48 bits
// - Sector count from two words, 48 bits
// - Command code in bits 2:0
// - Command write issues core request
// - Pattern select in bits 2:0
// - Full word drives timeout setting
// - Status word: busy, error, verify fail
// - Capacity words plus sector-size mode bit
// - Error kind, capability, probe pins read
// - Link up bit and split speed code
// - Lane width and LTSSM in link status
// - Admin and I/O completion codes packed
module user_register_block (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register interface from the crossing bridge
    input wire logic [`UR_WORD_ADDR_W-1:0] i_shared_word_address,
    input wire logic i_write_strobe,
    input wire logic [31:0] i_write_data,
    input wire logic [3:0] i_write_byte_lanes,
    input wire logic i_read_request_strobe,
    output logic o_read_valid_strobe,
    output logic [31:0] o_read_data,
    // Settings toward the core and pattern tester
    output logic [47:0] o_start_sector,
    output logic [47:0] o_sector_count,
    output logic [2:0] o_command_code,
    output logic o_command_request,
    output logic [2:0] o_pattern_select,
    output logic [31:0] o_timeout_setting,
    // Status from the core and pattern tester
    input wire logic i_core_busy_flag,
    input wire logic i_core_error_flag,
    input wire logic i_verify_fail_flag,
    input wire logic [47:0] i_disk_capacity,
    input wire logic i_sector_size_mode,
    input wire logic [31:0] i_error_kind,
    input wire logic [15:0] i_admin_completion_code,
    input wire logic [15:0] i_io_completion_code,
    input wire logic [31:0] i_drive_capability_word,
    input wire logic [31:0] i_core_probe_pins,
    // Link status
    input wire logic i_link_up,
    input wire logic [2:0] i_link_speed,
    input wire logic [3:0] i_link_width,
    input wire logic [5:0] i_ltssm_state,
    // Custom command queue words
    output logic [32*`UR_SUBQ_DEPTH-1:0] o_custom_submission,
    input wire logic [127:0] i_custom_completion,
    // Identify buffer read port, one cycle latency
    output logic o_identify_rd_en,
    output logic [`UR_BUF_ADDR_W-1:0] o_identify_rd_addr,
    input wire logic [31:0] i_identify_rd_data,
    // Custom buffer port, one cycle read latency
    output logic o_custom_rd_en,
    output logic [`UR_BUF_ADDR_W-1:0] o_custom_rd_addr,
    input wire logic [31:0] i_custom_rd_data,
    output logic o_custom_wr_en,
    output logic [`UR_BUF_ADDR_W-1:0] o_custom_wr_addr,
    output logic [31:0] o_custom_wr_data
);

    // ----------------------------------------
    // Address decode
    // ----------------------------------------

    logic [`UR_BYTE_ADDR_W-1:0] byte_addr; // Word address scaled to bytes
    user_register_block_pkg::window_e win; // Window hit by this access
    logic wr_ctrl; // Write landing in control window
    logic wr_csub; // Write landing in submission words
    logic [3:0] csub_idx; // Submission word index

    // Byte lanes are deliberately unused: the register file is word-only
    assign byte_addr = {i_shared_word_address, 2'b00};

    // Top bits choose buffer or register area, then bits 9:8 the sub-area
    always_comb begin
        win = user_register_block_pkg::WIN_NONE;
        if (byte_addr[14:13] == `UR_TOP_IDEN) begin
            win = user_register_block_pkg::WIN_IDEN;
        end else if (byte_addr[14:13] == `UR_TOP_CBUF) begin
            win = user_register_block_pkg::WIN_CBUF;
        end else if (byte_addr[14:10] == 5'h00) begin
            if (byte_addr[9:8] == `UR_SUB_CTRL) begin
                win = user_register_block_pkg::WIN_CTRL;
            end else if (byte_addr[9:8] == `UR_SUB_STAT) begin
                win = user_register_block_pkg::WIN_STAT;
            end else if (byte_addr[9:8] == `UR_SUB_CSUB) begin
                win = user_register_block_pkg::WIN_CSUB;
            end else begin
                win = user_register_block_pkg::WIN_CCOMP;
            end
        end
    end

    // Only write-enabled windows accept a strobe; status and identify drop it
    assign wr_ctrl = i_write_strobe && (win == user_register_block_pkg::WIN_CTRL);
    assign wr_csub = i_write_strobe && (win == user_register_block_pkg::WIN_CSUB)
                     && (byte_addr[7:6] == 2'b00);
    assign csub_idx = byte_addr[5:2];

    // ----------------------------------------
    // Control words
    // ----------------------------------------

    // Start sector, 48 bits from low and high words
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_start_sector <= `UR_RST_WIDE;
        end else if (wr_ctrl && byte_addr == `UR_OFS_START_LO) begin
            o_start_sector[31:0] <= i_write_data;
        end else if (wr_ctrl && byte_addr == `UR_OFS_START_HI) begin
            o_start_sector[47:32] <= i_write_data[15:0];
        end
    end

    // Sector count, 48 bits from low and high words
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_sector_count <= `UR_RST_WIDE;
        end else if (wr_ctrl && byte_addr == `UR_OFS_LEN_LO) begin
            o_sector_count[31:0] <= i_write_data;
        end else if (wr_ctrl && byte_addr == `UR_OFS_LEN_HI) begin
            o_sector_count[47:32] <= i_write_data[15:0];
        end
    end

    // Command code and its request pulse; reserved codes pass to the core as is
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_command_code <= `UR_RST_CODE;
            o_command_request <= 1'b0;
        end else begin
            o_command_request <= wr_ctrl && (byte_addr == `UR_OFS_COMMAND);
            if (wr_ctrl && byte_addr == `UR_OFS_COMMAND) begin
                o_command_code <= i_write_data[2:0];
            end
        end
    end

    // Pattern select for the tester
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_pattern_select <= `UR_RST_CODE;
        end else if (wr_ctrl && byte_addr == `UR_OFS_PATTERN) begin
            o_pattern_select <= i_write_data[2:0];
        end
    end

    // Timeout setting, whole word
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_timeout_setting <= `UR_RST_WORD;
        end else if (wr_ctrl && byte_addr == `UR_OFS_TIMEOUT) begin
            o_timeout_setting <= i_write_data;
        end
    end

    // ----------------------------------------
    // Custom submission words
    // ----------------------------------------

    // One word register per entry; writes past 0x23F hit nothing
    genvar gi;
    generate
        for (gi = 0; gi < `UR_SUBQ_DEPTH; gi = gi + 1) begin : g_subq
            always_ff @(posedge i_clk or posedge i_rst) begin
                if (i_rst) begin
                    o_custom_submission[32*gi +: 32] <= `UR_RST_WORD;
                end else if (wr_csub && csub_idx == 4'(gi)) begin
                    o_custom_submission[32*gi +: 32] <= i_write_data;
                end
            end
        end
    endgenerate

    // ----------------------------------------
    // Buffer ports
    // ----------------------------------------

    // Read addresses follow the shared address, which the bridge holds
    assign o_identify_rd_addr = byte_addr[12:2];
    assign o_custom_rd_addr = byte_addr[12:2];
    assign o_identify_rd_en = i_read_request_strobe && (win == user_register_block_pkg::WIN_IDEN);
    assign o_custom_rd_en = i_read_request_strobe && (win == user_register_block_pkg::WIN_CBUF);

    // Custom buffer write is registered; identify buffer has no write path
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_custom_wr_en <= 1'b0;
            o_custom_wr_addr <= {`UR_BUF_ADDR_W{1'b0}};
            o_custom_wr_data <= `UR_RST_WORD;
        end else begin
            o_custom_wr_en <= i_write_strobe && (win == user_register_block_pkg::WIN_CBUF);
            if (i_write_strobe && win == user_register_block_pkg::WIN_CBUF) begin
                o_custom_wr_addr <= byte_addr[12:2];
                o_custom_wr_data <= i_write_data;
            end
        end
    end

    // ----------------------------------------
    // Read path, first mux level
    // ----------------------------------------

    logic [31:0] reg_rd; // Word picked inside register area
    logic [31:0] link_word; // Packed link status
    logic rd_pend_r; // Request one cycle old
    user_register_block_pkg::window_e win_r; // Window of pending read
    logic [31:0] reg_rd_r; // Registered register-area word

    // Speed code is split: two low bits at 3:2, top bit at 16
    always_comb begin
        link_word = `UR_RST_WORD;
        link_word[`UR_BIT_LINK_UP] = i_link_up;
        link_word[3:2] = i_link_speed[1:0];
        link_word[`UR_BIT_SPEED_MSB] = i_link_speed[2];
        link_word[7:4] = i_link_width;
        link_word[13:8] = i_ltssm_state;
    end

    // Low address bits select a word; write-only and holes read zero
    always_comb begin
        reg_rd = `UR_RST_WORD;
        if (win == user_register_block_pkg::WIN_STAT) begin
            if (byte_addr == `UR_OFS_CORE_STATUS) begin
                reg_rd[`UR_BIT_BUSY] = i_core_busy_flag;
                reg_rd[`UR_BIT_ERROR] = i_core_error_flag;
                reg_rd[`UR_BIT_VERIFY_FAIL] = i_verify_fail_flag;
            end else if (byte_addr == `UR_OFS_CAP_LO) begin
                reg_rd = i_disk_capacity[31:0];
            end else if (byte_addr == `UR_OFS_CAP_HI) begin
                reg_rd[15:0] = i_disk_capacity[47:32];
                reg_rd[`UR_BIT_SECTOR_MODE] = i_sector_size_mode;
            end else if (byte_addr == `UR_OFS_ERROR_KIND) begin
                reg_rd = i_error_kind;
            end else if (byte_addr == `UR_OFS_LINK_STATUS) begin
                reg_rd = link_word;
            end else if (byte_addr == `UR_OFS_COMPLETION) begin
                reg_rd = {i_io_completion_code, i_admin_completion_code};
            end else if (byte_addr == `UR_OFS_CAPABILITY) begin
                reg_rd = i_drive_capability_word;
            end else if (byte_addr == `UR_OFS_PROBE_PINS) begin
                reg_rd = i_core_probe_pins;
            end
        end else if (win == user_register_block_pkg::WIN_CCOMP && byte_addr[7:4] == 4'h0) begin
            reg_rd = i_custom_completion[32*byte_addr[3:2] +: 32];
        end
    end

    // Stage one: capture register word and window, buffers answer meanwhile
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            rd_pend_r <= 1'b0;
            win_r <= user_register_block_pkg::WIN_NONE;
            reg_rd_r <= `UR_RST_WORD;
        end else begin
            rd_pend_r <= i_read_request_strobe;
            if (i_read_request_strobe) begin
                win_r <= win;
                reg_rd_r <= reg_rd;
            end
        end
    end

    // ----------------------------------------
    // Read path, second mux level
    // ----------------------------------------

    // Stage two: upper bits pick among sub-units; data held until next read
    always_ff @(posedge i_clk or posedge i_rst) begin
        if (i_rst) begin
            o_read_valid_strobe <= 1'b0;
            o_read_data <= `UR_RST_WORD;
        end else begin
            o_read_valid_strobe <= rd_pend_r;
            if (rd_pend_r) begin
                if (win_r == user_register_block_pkg::WIN_IDEN) begin
                    o_read_data <= i_identify_rd_data;
                end else if (win_r == user_register_block_pkg::WIN_CBUF) begin
                    o_read_data <= i_custom_rd_data;
                end else begin
                    o_read_data <= reg_rd_r;
                end
            end
        end
    end

endmodule

// ---- sim/reg_block_monitor.sv ----
`timescale 1ns/1ps
`include "user_register_block_params.svh"
// ----------------------------------------
// Register bus and control output checker
// ----------------------------------------
module reg_block_monitor (
    // Clock and reset
    input wire logic i_clk,
    input wire logic i_rst,
    // Register bus
    input wire logic [`UR_WORD_ADDR_W-1:0] i_shared_word_address,
    input wire logic i_write_strobe,
    input wire logic [31:0] i_write_data,
    input wire logic i_read_request_strobe,
    input wire logic o_read_valid_strobe,
    input wire logic [31:0] o_read_data,
    // Control outputs and buffer ports
    input wire logic [2:0] o_command_code,
    input wire logic o_command_request,
    input wire logic [31:0] o_timeout_setting,
    input wire logic o_identify_rd_en,
    input wire logic o_custom_wr_en,
    input wire logic [31:0] o_custom_wr_data
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    // Decoded writes, kept as signals so $past sees plain nets
    logic cmd_wr;
    logic to_wr;
    logic cb_wr;
    assign cmd_wr = i_write_strobe && i_shared_word_address == 13'h0004;
    assign to_wr = i_write_strobe && i_shared_word_address == 13'h0008;
    assign cb_wr = i_write_strobe && i_shared_word_address[12:11] == 2'h2;
    // Read pipeline steps
    sequence read_taken;
        i_read_request_strobe;
    endsequence
    sequence wo_taken;
        i_read_request_strobe && i_shared_word_address[12:6] == 7'h00;
    endsequence
    sequence answer_two;
        ##2 o_read_valid_strobe;
    endsequence
    read_latency_a: assert property (read_taken |-> answer_two)
        else $error("read valid not after two cycles");
    valid_source_a: assert property (o_read_valid_strobe |-> $past(i_read_request_strobe, 2))
        else $error("read valid without request");
    wo_read_zero_a: assert property (wo_taken |-> ##2 o_read_data == 32'h0)
        else $error("write-only word read nonzero");
    cmd_pulse_a: assert property (cmd_wr |=> o_command_request ##1 !o_command_request)
        else $error("command request not one pulse");
    req_cause_a: assert property (o_command_request |-> $past(cmd_wr))
        else $error("stray command request");
    cmd_code_a: assert property (cmd_wr |=> o_command_code == $past(i_write_data[2:0]))
        else $error("command code not loaded");
    timeout_load_a: assert property (to_wr |=> o_timeout_setting == $past(i_write_data))
        else $error("timeout not loaded whole");
    timeout_hold_a: assert property (!to_wr |=> $stable(o_timeout_setting))
        else $error("timeout changed");
    iden_select_a: assert property (o_identify_rd_en ==
        (i_read_request_strobe && i_shared_word_address[12:11] == 2'h1))
        else $error("identify enable wrong");
    cbuf_write_a: assert property (cb_wr |=>
        o_custom_wr_en && o_custom_wr_data == $past(i_write_data))
        else $error("custom buffer write lost");
    no_stray_write_a: assert property (o_custom_wr_en |-> $past(cb_wr))
        else $error("buffer written outside window");
endmodule
bind user_register_block reg_block_monitor i_mon (.i_clk, .i_rst, .i_shared_word_address, .i_write_strobe,
    .i_write_data, .i_read_request_strobe, .o_read_valid_strobe, .o_read_data, .o_command_code, .o_command_request,
    .o_timeout_setting, .o_identify_rd_en, .o_custom_wr_en, .o_custom_wr_data);

// ---- sim/reg_bridge_model.sv ----
`timescale 1ns/1ps
`include "user_register_block_params.svh"
// ----------------------------------------
// Crossing bridge model, register side
// ----------------------------------------
module reg_bridge_model (
    // Clock and read answer
    input wire logic i_clk,
    input wire logic i_read_valid_strobe,
    input wire logic [31:0] i_read_data,
    // Requests toward the block
    output logic [`UR_WORD_ADDR_W-1:0] o_shared_word_address = '0,
    output logic o_write_strobe = 1'b0,
    output logic [31:0] o_write_data = '0,
    output logic [3:0] o_write_byte_lanes = '0,
    output logic o_read_request_strobe = 1'b0
);
    // One-cycle strobe, word address, lanes left clear on purpose
    task automatic wr(input logic [14:0] a, input logic [31:0] d);
        @(posedge i_clk);
        o_shared_word_address <= a[14:2];
        o_write_data <= d;
        o_write_byte_lanes <= 4'h0;
        o_write_strobe <= 1'b1;
        @(posedge i_clk);
        o_write_strobe <= 1'b0;
        o_write_data <= ~d; // Stale data no longer valid
    endtask
    // Address held until the answer, never with a write
    task automatic rd(input logic [14:0] a, output logic [31:0] d, output logic ok);
        ok = 1'b0;
        d = 32'h0;
        @(posedge i_clk);
        o_shared_word_address <= a[14:2];
        o_read_request_strobe <= 1'b1;
        @(posedge i_clk);
        o_read_request_strobe <= 1'b0;
        for (int n = 0; n < 6 && !ok; n++) begin
            @(posedge i_clk);
            if (i_read_valid_strobe) begin
                ok = 1'b1;
                d = i_read_data;
            end
        end
    endtask
endmodule

// ---- sim/tb.sv ----
`timescale 1ns/1ps
`include "user_register_block_params.svh"
module tb;
    // ----------------------------------------
    // Wiring
    // ----------------------------------------
    logic i_clk = 1'b0;
    logic i_rst = 1'b1;
    logic [`UR_WORD_ADDR_W-1:0] i_shared_word_address;
    logic i_write_strobe, i_read_request_strobe, o_read_valid_strobe, o_command_request;
    logic [31:0] i_write_data, o_read_data, o_timeout_setting, i_error_kind, i_drive_capability_word;
    logic [31:0] i_core_probe_pins, i_identify_rd_data, i_custom_rd_data, o_custom_wr_data;
    logic [3:0] i_write_byte_lanes;
    logic [3:0] i_link_width = 4'h4;
    logic [47:0] o_start_sector, o_sector_count;
    logic [2:0] o_command_code, o_pattern_select;
    logic [2:0] i_link_speed = 3'h7;
    logic i_core_busy_flag = 1'b1;
    logic i_core_error_flag = 1'b0;
    logic i_verify_fail_flag = 1'b1;
    logic i_sector_size_mode = 1'b1;
    logic i_link_up = 1'b1;
    logic [47:0] i_disk_capacity = 48'h1234_89ab_cdef;
    logic [15:0] i_admin_completion_code = 16'h00a1;
    logic [15:0] i_io_completion_code = 16'h0b02;
    logic [5:0] i_ltssm_state = 6'h2d;
    logic [32*`UR_SUBQ_DEPTH-1:0] o_custom_submission;
    logic [127:0] i_custom_completion = 128'hd3d3_d3d3_c2c2_c2c2_b1b1_b1b1_a0a0_a0a0;
    logic o_identify_rd_en, o_custom_rd_en, o_custom_wr_en;
    logic [`UR_BUF_ADDR_W-1:0] o_identify_rd_addr, o_custom_rd_addr, o_custom_wr_addr;
    int n_fail = 0;
    int checks = 0;
    always #2 i_clk = ~i_clk;
    // Buffers: one-cycle read, scrambled when not enabled
    always @(posedge i_clk) begin
        i_identify_rd_data <= o_identify_rd_en ? {16'h1d00, 5'h0, o_identify_rd_addr} : ~i_identify_rd_data;
        i_custom_rd_data <= o_custom_rd_en ? {16'hc0de, 5'h0, o_custom_rd_addr} : ~i_custom_rd_data;
    end
    initial i_identify_rd_data = 32'h0;
    initial i_custom_rd_data = 32'h0;
    initial i_error_kind = 32'h0e0e_7001;
    initial i_drive_capability_word = 32'h0fa0_3fff;
    initial i_core_probe_pins = 32'h5a5a_0c0c;
    user_register_block i_dut (.i_clk, .i_rst, .i_shared_word_address, .i_write_strobe, .i_write_data,
        .i_write_byte_lanes, .i_read_request_strobe, .o_read_valid_strobe, .o_read_data, .o_start_sector,
        .o_sector_count, .o_command_code, .o_command_request, .o_pattern_select, .o_timeout_setting,
        .i_core_busy_flag, .i_core_error_flag, .i_verify_fail_flag, .i_disk_capacity, .i_sector_size_mode,
        .i_error_kind, .i_admin_completion_code, .i_io_completion_code, .i_drive_capability_word,
        .i_core_probe_pins, .i_link_up, .i_link_speed, .i_link_width, .i_ltssm_state, .o_custom_submission,
        .i_custom_completion, .o_identify_rd_en, .o_identify_rd_addr, .i_identify_rd_data, .o_custom_rd_en,
        .o_custom_rd_addr, .i_custom_rd_data, .o_custom_wr_en, .o_custom_wr_addr, .o_custom_wr_data);
    reg_bridge_model i_br (.i_clk, .i_read_valid_strobe(o_read_valid_strobe), .i_read_data(o_read_data),
        .o_shared_word_address(i_shared_word_address), .o_write_strobe(i_write_strobe),
        .o_write_data(i_write_data), .o_write_byte_lanes(i_write_byte_lanes),
        .o_read_request_strobe(i_read_request_strobe));
    // ----------------------------------------
    // Shared helpers
    // ----------------------------------------
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp) begin
            n_fail++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Read with answer flag folded into the compare
    task automatic rc(input logic [14:0] a, input logic [31:0] exp);
        logic [31:0] d;
        logic ok;
        i_br.rd(a, d, ok);
        chk({31'h0, ok, d}, {32'h1, exp});
    endtask
    task automatic stop_test;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_control;
        i_br.wr(15'h0000, 32'h89ab_cdef);
        i_br.wr(15'h0004, 32'hffff_1234);
        i_br.wr(15'h0008, 32'h0000_0200);
        i_br.wr(15'h000c, 32'hdead_0001);
        i_br.wr(15'h0014, {29'h0, user_register_block_pkg::PAT_LFSR});
        i_br.wr(15'h0020, 32'hfedc_ba98);
        #1;
        chk(o_start_sector, 48'h1234_89ab_cdef);
        chk(o_sector_count, 48'h0001_0000_0200);
        chk(o_pattern_select, 3'h4);
        chk(o_timeout_setting, 32'hfedc_ba98);
        rc(15'h0020, 32'h0);
        rc(15'h0004, 32'h0);
        $display("t_control done");
    endtask
    // Every code, reserved ones too, upper data bits set
    task automatic t_command;
        for (int c = 0; c < 8; c++) begin
            i_br.wr(15'h0010, 32'hffff_fff8 | 32'(c));
            #1;
            chk(o_command_code, 64'(c));
            chk(o_command_request, 64'h1);
            @(posedge i_clk);
            #1;
            chk(o_command_request, 64'h0);
        end
        $display("t_command done");
    endtask
    task automatic t_status;
        logic [31:0] exp [8];
        exp = '{32'h5, 32'h89ab_cdef, 32'h8000_1234, 32'h0e0e_7001, 32'h0001_2d4d, 32'h0b02_00a1,
            32'h0fa0_3fff, 32'h5a5a_0c0c};
        for (int i = 0; i < 8; i++) begin
            rc(15'h0100 + 15'(4 * i), exp[i]);
        end
        // Flip every status flag so each bit is proven to follow its own input
        {i_core_busy_flag, i_core_error_flag, i_verify_fail_flag} <= 3'b010;
        rc(15'h0100, 32'h2);
        $display("t_status done");
    endtask
    task automatic t_custom;
        i_br.wr(15'h0204, 32'h5151_a0a0);
        #1;
        chk(o_custom_submission[63:32], 32'h5151_a0a0);
        rc(15'h0208, 32'h0);
        rc(15'h030c, 32'hd3d3_d3d3);
        i_br.wr(15'h4010, 32'h7e57_0001);
        #1;
        chk({o_custom_wr_en, o_custom_wr_addr, o_custom_wr_data}, {1'b1, 11'h004, 32'h7e57_0001});
        rc(15'h4ffc, {16'hc0de, 5'h0, 11'h3ff});
        rc(15'h2004, {16'h1d00, 5'h0, 11'h001});
        rc(15'h3ffc, {16'h1d00, 5'h0, 11'h7ff});
        i_br.wr(15'h2008, 32'h0);
        #1;
        chk(o_custom_wr_en, 64'h0);
        i_br.wr(15'h0120, 32'h0);
        #1;
        chk(o_timeout_setting, 32'hfedc_ba98);
        $display("t_custom done");
    endtask
    task automatic t_unmapped;
        rc(15'h6000, 32'h0);
        rc(15'h0800, 32'h0);
        rc(15'h7ffc, 32'h0);
        $display("t_unmapped done");
    endtask
    // Mid-run reset clears the settings; the bus must work right after release
    task automatic t_reset;
        @(posedge i_clk);
        i_rst <= 1'b1;
        repeat (2) @(posedge i_clk);
        chk({o_start_sector, o_command_code, o_pattern_select}, 64'h0);
        chk({o_timeout_setting, o_custom_submission[63:32]}, 64'h0);
        i_rst <= 1'b0;
        i_br.wr(15'h0020, 32'h0000_7777);
        #1;
        chk(o_timeout_setting, 32'h0000_7777);
        $display("t_reset done");
    endtask
    // ----------------------------------------
    // Main sequence and watchdog
    // ----------------------------------------
    initial begin
        repeat (2) @(posedge i_clk);
        i_rst <= 1'b0;
        t_control;
        t_command;
        t_status;
        t_custom;
        t_unmapped;
        t_reset;
        stop_test;
    end
    initial begin
        #20000;
        n_fail++;
        $display("watchdog expired");
        stop_test;
    end
endmodule
